/* hdl/ddr2_cmd_pkg.sv */
// ddr2_cmd_pkg: shared constants for the ddr2 sdram command interface.
// assumes the core clock is the memory clock (rising crossing) at 40 MHz.
package ddr2_cmd_pkg;

	// ------------------------------------------------------------------
	// geometry
	// ------------------------------------------------------------------
	localparam int NUM_BANKS  = 4;
	localparam int BANK_W     = 2;
	localparam int ROW_W      = 13;
	localparam int COL_W      = 10;
	localparam int DATA_W     = 16;
	localparam int LANE_W     = 8;
	localparam int NUM_LANES  = 2;
	localparam int AP_BIT     = 10;
	// storage keeps only the low row bits; higher rows alias onto them
	localparam int ROW_KEEP_W = 2;
	localparam int MEM_IDX_W  = BANK_W + ROW_KEEP_W + COL_W;
	localparam int MEM_WORDS  = 1 << MEM_IDX_W;

	// ------------------------------------------------------------------
	// latency and timing
	// ------------------------------------------------------------------
	localparam int            CLK_PERIOD_PS = 25000;
	localparam int            T_RCD_1066_PS = 13125;
	localparam int            T_RCD_800_PS  = 12500;
	localparam int            T_RCD_667_PS  = 15000;
	localparam int            TMR_W         = 4;
	localparam logic [TMR_W-1:0] RCD_1066_CYC =
		TMR_W'((T_RCD_1066_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [TMR_W-1:0] RCD_800_CYC =
		TMR_W'((T_RCD_800_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [TMR_W-1:0] RCD_667_CYC =
		TMR_W'((T_RCD_667_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [4:0]    CL_1066       = 5'h07;
	localparam logic [4:0]    CL_800_667    = 5'h05;
	localparam logic [2:0]    AL_MAX        = 3'h6;
	localparam logic [1:0]    BL4_LAST_STEP = 2'h1;
	localparam logic [1:0]    BL8_LAST_STEP = 2'h3;
	localparam int            PIPE_DEPTH    = 16;
	localparam int            PIPE_W        = 4;

	// ------------------------------------------------------------------
	// speed grade select codes
	// ------------------------------------------------------------------
	localparam logic [1:0] GRADE_1066 = 2'h0;
	localparam logic [1:0] GRADE_800  = 2'h1;
	localparam logic [1:0] GRADE_667  = 2'h2;

	typedef enum logic [2:0] {
		CMD_NOP,
		CMD_ACTIVATE,
		CMD_PRECHARGE,
		CMD_READ,
		CMD_WRITE,
		CMD_REFRESH,
		CMD_MODE_SET
	} cmd_e;

endpackage

/* hdl/burst_column_order.sv */
// burst_column_order: column addresses of the two beats of one clock.
// assumes start column and step are stable for the cycle; pure logic.
`timescale 1ns/1ps
module burst_column_order
	import ddr2_cmd_pkg::*;
(
	input  wire logic [COL_W-1:0] start_col_i,
	input  wire logic [1:0]       step_i,
	input  wire logic             burst_len8_i,
	input  wire logic             interleave_i,
	output logic      [COL_W-1:0] col_even_o,
	output logic      [COL_W-1:0] col_odd_o
);

	// ------------------------------------------------------------------
	// beat to column mapping
	// ------------------------------------------------------------------
	function automatic logic [COL_W-1:0] beat_col(
		input logic [COL_W-1:0] start,
		input logic [2:0]       beat,
		input logic             bl8,
		input logic             il
	);
		logic [2:0] low;
		low = il ? (start[2:0] ^ beat) : (start[2:0] + beat);
		// wrap stays inside the 4 or 8 beat block
		if (bl8) begin
			beat_col = {start[COL_W-1:3], low};
		end else begin
			beat_col = {start[COL_W-1:2], low[1:0]};
		end
	endfunction

	always_comb begin
		col_even_o = beat_col(start_col_i, {step_i, 1'b0},
			burst_len8_i, interleave_i);
		col_odd_o  = beat_col(start_col_i, {step_i, 1'b1},
			burst_len8_i, interleave_i);
	end

endmodule

/* hdl/ddr2_sdram_command_interface.sv */
// ddr2_sdram_command_interface: command decode, bank state, posted and
// cas latency pipe, burst engine and data storage of a 4-bank x16 ddr2.
// assumes the controller runs on sys_clk_i; each clock carries two beats.
//
// Overview of operation
// - command and address are captured on the rising clock crossing
// - read data leaves as two beats per clock, rise then fall
// - data moves with a strobe driven by whichever side sends
// - address carries row at activate, column at read or write
// - bursts of 4 or 8 beats, sequential or interleaved from start
// - auto precharge closes the row itself when the burst ends
// - clock enable low freezes all state and outputs except the power-down, self-refresh and previous-enable flags
// - clock enable low with banks idle enters power-down or self-refresh
// - bank select picks which of 4 banks a command targets
// - posted column delay of 0 to 6 clocks on column commands
// - write latency is read latency minus one clock
// - cas latency 7 or 5; row timings 13.125, 12.5 or 15 ns
// - chip select high masks every command
// - row strobe low, column strobe high: activate or precharge
// - column bits 0-9, bit 10 auto precharge, 13-bit row
// - byte mask high drops that write byte, low and high lanes
`timescale 1ns/1ps
module ddr2_sdram_command_interface
	import ddr2_cmd_pkg::*;
(
	input  wire logic                 sys_clk_i,
	input  wire logic                 reset_i,
	input  wire logic                 clk_en_i,
	input  wire logic                 chip_select_n_i,
	input  wire logic                 row_strobe_n_i,
	input  wire logic                 col_strobe_n_i,
	input  wire logic                 write_enable_n_i,
	input  wire logic [BANK_W-1:0]    bank_select_i,
	input  wire logic [ROW_W-1:0]     multiplexed_address_i,
	input  wire logic [DATA_W-1:0]    wr_data_rise_i,
	input  wire logic [DATA_W-1:0]    wr_data_fall_i,
	input  wire logic [NUM_LANES-1:0] byte_write_mask_rise_i,
	input  wire logic [NUM_LANES-1:0] byte_write_mask_fall_i,
	input  wire logic                 wr_strobe_i,
	input  wire logic [1:0]           speed_grade_i,
	input  wire logic [2:0]           posted_column_delay_i,
	input  wire logic                 burst_len8_i,
	input  wire logic                 burst_interleave_i,
	output logic      [DATA_W-1:0]    rd_data_rise_o,
	output logic      [DATA_W-1:0]    rd_data_fall_o,
	output logic                      data_oe_o,
	output logic                      strobe_oe_o,
	output logic      [NUM_BANKS-1:0] bank_open_o,
	output logic                      power_down_o,
	output logic                      self_refresh_o,
	output logic                      cmd_error_o
);

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function automatic logic [MEM_IDX_W-1:0] mem_index(
		input logic [BANK_W-1:0]     bank,
		input logic [ROW_KEEP_W-1:0] row_lo,
		input logic [COL_W-1:0]      col
	);
		mem_index = {bank, row_lo, col};
	endfunction

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	logic [DATA_W-1:0]     store_mem [MEM_WORDS];

	logic [NUM_BANKS-1:0]  open_r, open_nxt;
	logic [ROW_W-1:0]      row_r [NUM_BANKS];
	logic [ROW_W-1:0]      row_nxt [NUM_BANKS];
	logic [TMR_W-1:0]      tmr_r [NUM_BANKS];
	logic [TMR_W-1:0]      tmr_nxt [NUM_BANKS];

	logic [PIPE_DEPTH-1:0] pipe_v_r, pipe_v_nxt;
	logic [PIPE_DEPTH-1:0] pipe_wr_r, pipe_wr_nxt;
	logic [PIPE_DEPTH-1:0] pipe_ap_r, pipe_ap_nxt;
	logic [BANK_W-1:0]     pipe_bank_r [PIPE_DEPTH];
	logic [BANK_W-1:0]     pipe_bank_nxt [PIPE_DEPTH];
	logic [COL_W-1:0]      pipe_col_r [PIPE_DEPTH];
	logic [COL_W-1:0]      pipe_col_nxt [PIPE_DEPTH];
	logic [ROW_KEEP_W-1:0] pipe_row_r [PIPE_DEPTH];
	logic [ROW_KEEP_W-1:0] pipe_row_nxt [PIPE_DEPTH];

	logic                  bst_active_r, bst_active_nxt;
	logic                  bst_wr_r, bst_wr_nxt;
	logic                  bst_ap_r, bst_ap_nxt;
	logic                  bst_bl8_r, bst_bl8_nxt;
	logic                  bst_il_r, bst_il_nxt;
	logic [1:0]            bst_step_r, bst_step_nxt;
	logic [BANK_W-1:0]     bst_bank_r, bst_bank_nxt;
	logic [COL_W-1:0]      bst_col_r, bst_col_nxt;
	logic [ROW_KEEP_W-1:0] bst_row_r, bst_row_nxt;

	logic [DATA_W-1:0]     rd_rise_r, rd_rise_nxt;
	logic [DATA_W-1:0]     rd_fall_r, rd_fall_nxt;
	logic                  data_oe_r, data_oe_nxt;
	logic                  strobe_oe_r, strobe_oe_nxt;
	logic                  err_r, err_nxt;
	logic                  cke_prev_r;
	logic                  pd_r, pd_nxt;
	logic                  sr_r, sr_nxt;

	cmd_e                  cmd;
	logic [4:0]            cas_lat;
	logic [4:0]            read_lat;
	logic [2:0]            add_lat;
	logic [TMR_W-1:0]      trcd_cyc;
	logic [PIPE_W-1:0]     ins;
	logic [COL_W-1:0]      col_even, col_odd;
	logic [MEM_IDX_W-1:0]  idx_even, idx_odd;

	// ------------------------------------------------------------------
	// command decode and latency selection
	// ------------------------------------------------------------------
	always_comb begin
		cmd = CMD_NOP;
		if (!chip_select_n_i) begin
			case ({row_strobe_n_i, col_strobe_n_i, write_enable_n_i})
				3'b011:  cmd = CMD_ACTIVATE;
				3'b010:  cmd = CMD_PRECHARGE;
				3'b101:  cmd = CMD_READ;
				3'b100:  cmd = CMD_WRITE;
				3'b001:  cmd = CMD_REFRESH;
				3'b000:  cmd = CMD_MODE_SET;
				default: cmd = CMD_NOP;
			endcase
		end
		case (speed_grade_i)
			GRADE_1066: begin
				cas_lat  = CL_1066;
				trcd_cyc = RCD_1066_CYC;
			end
			GRADE_800: begin
				cas_lat  = CL_800_667;
				trcd_cyc = RCD_800_CYC;
			end
			default: begin
				cas_lat  = CL_800_667;
				trcd_cyc = RCD_667_CYC;
			end
		endcase
		// out-of-range delays clamp rather than overrun the pipe
		add_lat  = (posted_column_delay_i > AL_MAX) ? AL_MAX
			: posted_column_delay_i;
		read_lat = cas_lat + {2'h0, add_lat};
		// one slot serves both: reads emerge at rl, write data is
		// taken from the clock after wl = rl - 1
		ins      = PIPE_W'(read_lat - 5'h02);
	end

	burst_column_order u_order (
		.start_col_i  (bst_col_r),
		.step_i       (bst_step_r),
		.burst_len8_i (bst_bl8_r),
		.interleave_i (bst_il_r),
		.col_even_o   (col_even),
		.col_odd_o    (col_odd)
	);

	assign idx_even = mem_index(bst_bank_r, bst_row_r, col_even);
	assign idx_odd  = mem_index(bst_bank_r, bst_row_r, col_odd);

	// ------------------------------------------------------------------
	// next state: banks, pipe, burst, read data
	// ------------------------------------------------------------------
	always_comb begin
		open_nxt       = open_r;
		row_nxt        = row_r;
		tmr_nxt        = tmr_r;
		pipe_v_nxt     = pipe_v_r;
		pipe_wr_nxt    = pipe_wr_r;
		pipe_ap_nxt    = pipe_ap_r;
		pipe_bank_nxt  = pipe_bank_r;
		pipe_col_nxt   = pipe_col_r;
		pipe_row_nxt   = pipe_row_r;
		bst_active_nxt = bst_active_r;
		bst_wr_nxt     = bst_wr_r;
		bst_ap_nxt     = bst_ap_r;
		bst_bl8_nxt    = bst_bl8_r;
		bst_il_nxt     = bst_il_r;
		bst_step_nxt   = bst_step_r;
		bst_bank_nxt   = bst_bank_r;
		bst_col_nxt    = bst_col_r;
		bst_row_nxt    = bst_row_r;
		rd_rise_nxt    = rd_rise_r;
		rd_fall_nxt    = rd_fall_r;
		data_oe_nxt    = data_oe_r;
		strobe_oe_nxt  = strobe_oe_r;
		err_nxt        = err_r;
		if (clk_en_i) begin
			err_nxt = 1'b0;
			for (int b = 0; b < NUM_BANKS; b++) begin
				if (tmr_r[b] != '0)
					tmr_nxt[b] = tmr_r[b] - 4'h1;
			end
			for (int i = 0; i < PIPE_DEPTH - 1; i++) begin
				pipe_v_nxt[i]    = pipe_v_r[i+1];
				pipe_wr_nxt[i]   = pipe_wr_r[i+1];
				pipe_ap_nxt[i]   = pipe_ap_r[i+1];
				pipe_bank_nxt[i] = pipe_bank_r[i+1];
				pipe_col_nxt[i]  = pipe_col_r[i+1];
				pipe_row_nxt[i]  = pipe_row_r[i+1];
			end
			pipe_v_nxt[PIPE_DEPTH-1] = 1'b0;

			if (bst_active_r) begin
				if (bst_step_r == (bst_bl8_r ? BL8_LAST_STEP
						: BL4_LAST_STEP)) begin
					bst_active_nxt = 1'b0;
					if (bst_ap_r) begin
						open_nxt[bst_bank_r] = 1'b0;
						tmr_nxt[bst_bank_r]  = trcd_cyc;
					end
				end else begin
					bst_step_nxt = bst_step_r + 2'h1;
				end
			end
			if (pipe_v_r[0]) begin
				bst_active_nxt = 1'b1;
				bst_step_nxt   = 2'h0;
				bst_wr_nxt     = pipe_wr_r[0];
				bst_ap_nxt     = pipe_ap_r[0];
				bst_bank_nxt   = pipe_bank_r[0];
				bst_col_nxt    = pipe_col_r[0];
				bst_row_nxt    = pipe_row_r[0];
				bst_bl8_nxt    = burst_len8_i;
				bst_il_nxt     = burst_interleave_i;
			end

			data_oe_nxt   = bst_active_r && !bst_wr_r;
			// one clock of strobe preamble ahead of the first beat
			strobe_oe_nxt = data_oe_nxt || (pipe_v_r[0] && !pipe_wr_r[0]);
			rd_rise_nxt   = data_oe_nxt ? store_mem[idx_even] : '0;
			rd_fall_nxt   = data_oe_nxt ? store_mem[idx_odd]  : '0;

			case (cmd)
				CMD_ACTIVATE: begin
					if (open_r[bank_select_i] || tmr_r[bank_select_i] > 4'h1)
						err_nxt = 1'b1;
					else begin
						open_nxt[bank_select_i] = 1'b1;
						row_nxt[bank_select_i]  = multiplexed_address_i;
						tmr_nxt[bank_select_i]  = trcd_cyc;
					end
				end
				CMD_PRECHARGE: begin
					for (int b = 0; b < NUM_BANKS; b++) begin
						if ((multiplexed_address_i[AP_BIT]
								|| BANK_W'(b) == bank_select_i)
								&& open_r[b]) begin
							open_nxt[b] = 1'b0;
							tmr_nxt[b]  = trcd_cyc;
						end
					end
				end
				CMD_READ, CMD_WRITE: begin
					if (!open_r[bank_select_i] || tmr_r[bank_select_i] > 4'h1)
						err_nxt = 1'b1;
					else begin
						pipe_v_nxt[ins]    = 1'b1;
						pipe_wr_nxt[ins]   = (cmd == CMD_WRITE);
						pipe_ap_nxt[ins]   =
							multiplexed_address_i[AP_BIT];
						pipe_bank_nxt[ins] = bank_select_i;
						pipe_col_nxt[ins]  =
							multiplexed_address_i[COL_W-1:0];
						pipe_row_nxt[ins]  =
							row_r[bank_select_i][ROW_KEEP_W-1:0];
					end
				end
				CMD_REFRESH: begin
					if (open_r != '0)
						err_nxt = 1'b1;
				end
				default: begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// low power states: these track the enable itself, so never frozen
	// ------------------------------------------------------------------
	always_comb begin
		sr_nxt = sr_r;
		if (clk_en_i) begin
			sr_nxt = 1'b0;
		end else if (cke_prev_r && cmd == CMD_REFRESH
				&& open_r == '0) begin
			sr_nxt = 1'b1;
		end
		pd_nxt = !clk_en_i && open_r == '0 && !sr_nxt;
	end

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			open_r       <= '0;
			pipe_v_r     <= '0;
			pipe_wr_r    <= '0;
			pipe_ap_r    <= '0;
			bst_active_r <= 1'b0;
			bst_wr_r     <= 1'b0;
			bst_ap_r     <= 1'b0;
			bst_bl8_r    <= 1'b0;
			bst_il_r     <= 1'b0;
			bst_step_r   <= 2'h0;
			bst_bank_r   <= '0;
			bst_col_r    <= '0;
			bst_row_r    <= '0;
			rd_rise_r    <= '0;
			rd_fall_r    <= '0;
			data_oe_r    <= 1'b0;
			strobe_oe_r  <= 1'b0;
			err_r        <= 1'b0;
			cke_prev_r   <= 1'b0;
			pd_r         <= 1'b0;
			sr_r         <= 1'b0;
			for (int i = 0; i < PIPE_DEPTH; i++) begin
				pipe_bank_r[i] <= '0;
				pipe_col_r[i]  <= '0;
				pipe_row_r[i]  <= '0;
			end
			for (int b = 0; b < NUM_BANKS; b++) begin
				row_r[b] <= '0;
				tmr_r[b] <= '0;
			end
		end else begin
			open_r       <= open_nxt;
			row_r        <= row_nxt;
			tmr_r        <= tmr_nxt;
			pipe_v_r     <= pipe_v_nxt;
			pipe_wr_r    <= pipe_wr_nxt;
			pipe_ap_r    <= pipe_ap_nxt;
			pipe_bank_r  <= pipe_bank_nxt;
			pipe_col_r   <= pipe_col_nxt;
			pipe_row_r   <= pipe_row_nxt;
			bst_active_r <= bst_active_nxt;
			bst_wr_r     <= bst_wr_nxt;
			bst_ap_r     <= bst_ap_nxt;
			bst_bl8_r    <= bst_bl8_nxt;
			bst_il_r     <= bst_il_nxt;
			bst_step_r   <= bst_step_nxt;
			bst_bank_r   <= bst_bank_nxt;
			bst_col_r    <= bst_col_nxt;
			bst_row_r    <= bst_row_nxt;
			rd_rise_r    <= rd_rise_nxt;
			rd_fall_r    <= rd_fall_nxt;
			data_oe_r    <= data_oe_nxt;
			strobe_oe_r  <= strobe_oe_nxt;
			err_r        <= err_nxt;
			cke_prev_r   <= clk_en_i;
			pd_r         <= pd_nxt;
			sr_r         <= sr_nxt;
		end
	end

	// storage has no reset; a beat is only taken while the strobe runs
	always_ff @(posedge sys_clk_i) begin
		if (clk_en_i && bst_active_r && bst_wr_r && wr_strobe_i) begin
			for (int l = 0; l < NUM_LANES; l++) begin
				if (!byte_write_mask_rise_i[l])
					store_mem[idx_even][l*LANE_W +: LANE_W] <=
						wr_data_rise_i[l*LANE_W +: LANE_W];
				if (!byte_write_mask_fall_i[l])
					store_mem[idx_odd][l*LANE_W +: LANE_W] <=
						wr_data_fall_i[l*LANE_W +: LANE_W];
			end
		end
	end

	assign rd_data_rise_o = rd_rise_r;
	assign rd_data_fall_o = rd_fall_r;
	assign data_oe_o      = data_oe_r;
	assign strobe_oe_o    = strobe_oe_r;
	assign bank_open_o    = open_r;
	assign power_down_o   = pd_r;
	assign self_refresh_o = sr_r;
	assign cmd_error_o    = err_r;

endmodule

/* tb/ddr2_cmd_chk.sv */
// ddr2_cmd_chk: concurrent checks on the command interface ports.
// assumes one clock domain, synchronous active-high reset.
`timescale 1ns/1ps
module ddr2_cmd_chk
	import ddr2_cmd_pkg::*;
(
	input wire logic                 sys_clk_i,
	input wire logic                 reset_i,
	input wire logic                 clk_en_i,
	input wire logic                 chip_select_n_i,
	input wire logic                 row_strobe_n_i,
	input wire logic                 col_strobe_n_i,
	input wire logic                 write_enable_n_i,
	input wire logic [BANK_W-1:0]    bank_select_i,
	input wire logic [DATA_W-1:0]    rd_data_rise_o,
	input wire logic [DATA_W-1:0]    rd_data_fall_o,
	input wire logic                 data_oe_o,
	input wire logic                 strobe_oe_o,
	input wire logic [NUM_BANKS-1:0] bank_open_o,
	input wire logic                 power_down_o,
	input wire logic                 self_refresh_o,
	input wire logic                 cmd_error_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (reset_i);

	wire logic       live = clk_en_i && !chip_select_n_i;
	wire logic [2:0] code = {row_strobe_n_i, col_strobe_n_i,
		write_enable_n_i};

	// ------
	// command sequences
	// ------
	sequence s_act;
		live && code == 3'h3 && !bank_open_o[bank_select_i];
	endsequence
	sequence s_col_shut;
		live && code[2:1] == 2'h2 && !bank_open_o[bank_select_i];
	endsequence
	sequence s_idle_low;
		!clk_en_i && bank_open_o == 4'h0;
	endsequence

	a_act_opens: assert property (s_act |=>
		bank_open_o[$past(bank_select_i)]) else $error("bank not opened");
	a_pre_closes: assert property (live && code == 3'h2 |=>
		!bank_open_o[$past(bank_select_i)]) else $error("bank not closed");
	a_col_refused: assert property (s_col_shut |=>
		cmd_error_o) else $error("column access to shut bank taken");
	a_cs_blocks: assert property (chip_select_n_i && clk_en_i |=>
		(bank_open_o & ~$past(bank_open_o)) == 4'h0 && !cmd_error_o)
		else $error("deselected command acted");
	a_strobe_lead: assert property ($rose(strobe_oe_o) |->
		!data_oe_o ##1 data_oe_o) else $error("strobe preamble wrong");
	a_strobe_covers: assert property (data_oe_o |-> strobe_oe_o)
		else $error("data without strobe");
	a_quiet_bus: assert property (!data_oe_o |->
		rd_data_rise_o == 16'h0 && rd_data_fall_o == 16'h0)
		else $error("read bus not quiet");
	a_freeze_hold: assert property (!clk_en_i |=>
		$stable(bank_open_o) && $stable(data_oe_o) &&
		$stable(rd_data_rise_o) && $stable(cmd_error_o))
		else $error("state moved with clock enable low");
	a_low_power: assert property (s_idle_low ##1 s_idle_low |->
		power_down_o || self_refresh_o) else $error("no low power entry");
endmodule

bind ddr2_sdram_command_interface ddr2_cmd_chk u_chk (
	.sys_clk_i(sys_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
	.chip_select_n_i(chip_select_n_i), .row_strobe_n_i(row_strobe_n_i),
	.col_strobe_n_i(col_strobe_n_i), .write_enable_n_i(write_enable_n_i),
	.bank_select_i(bank_select_i), .rd_data_rise_o(rd_data_rise_o),
	.rd_data_fall_o(rd_data_fall_o), .data_oe_o(data_oe_o),
	.strobe_oe_o(strobe_oe_o), .bank_open_o(bank_open_o),
	.power_down_o(power_down_o), .self_refresh_o(self_refresh_o),
	.cmd_error_o(cmd_error_o));

/* tb/ddr2_ctl_model.sv */
// ddr2_ctl_model: behavioural controller on the command and write side.
// assumes one caller process; write beats are scheduled by edge count.
`timescale 1ns/1ps
module ddr2_ctl_model
	import ddr2_cmd_pkg::*;
(
	input  wire logic                 sys_clk_i,
	output logic                      clk_en_o,
	output logic                      cs_n_o,
	output logic      [2:0]           code_o,
	output logic      [BANK_W-1:0]    bank_o,
	output logic      [ROW_W-1:0]     addr_o,
	output logic      [DATA_W-1:0]    d_rise_o,
	output logic      [DATA_W-1:0]    d_fall_o,
	output logic      [NUM_LANES-1:0] m_rise_o,
	output logic      [NUM_LANES-1:0] m_fall_o,
	output logic                      wstb_o
);
	int          cyc = 0;
	logic [35:0] plan [int];

	initial begin
		{clk_en_o, cs_n_o, code_o, bank_o, addr_o} = {5'h1F, 15'h0};
		{d_rise_o, d_fall_o, m_rise_o, m_fall_o, wstb_o} = 37'h0;
	end

	// released data lines toggle so a stale beat is never read as good
	always @(posedge sys_clk_i) begin
		cyc <= cyc + 1;
		wstb_o <= plan.exists(cyc);
		if (plan.exists(cyc))
			{d_rise_o, d_fall_o, m_rise_o, m_fall_o} <= plan[cyc];
		else
			{d_rise_o, d_fall_o} <= ~{d_rise_o, d_fall_o};
	end

	// e returns the edge count at which the command is sampled
	task automatic issue(input logic cs_n, input logic ce,
		input logic [2:0] code, input logic [1:0] b,
		input logic [12:0] a, output int e);
		@(posedge sys_clk_i);
		clk_en_o <= ce;
		cs_n_o <= cs_n;
		code_o <= code;
		bank_o <= b;
		addr_o <= a;
		e = cyc + 1;
		@(posedge sys_clk_i);
		cs_n_o <= 1'b1;
		code_o <= 3'h7;
		addr_o <= ~a;
	endtask
endmodule

/* tb/tb_top.sv */
// tb_top: random and corner traffic against the command interface.
// assumes the controller model owns every command and write-data pin.
`timescale 1ns/1ps
module tb_top
	import ddr2_cmd_pkg::*;
;
	logic             sys_clk_i = 1'b0;
	logic             reset_i   = 1'b1;
	logic [1:0]       grade     = 2'h0;
	logic [2:0]       pdly      = 3'h0;
	logic             bl8       = 1'b0;
	logic             il        = 1'b0;
	wire logic        clk_en_i, chip_select_n_i, wr_strobe_i, cmd_error_o;
	wire logic        row_strobe_n_i, col_strobe_n_i, write_enable_n_i;
	wire logic [1:0]  bank_select_i, msk_r, msk_f;
	wire logic [12:0] multiplexed_address_i;
	wire logic [15:0] wd_r, wd_f, rd_data_rise_o, rd_data_fall_o;
	wire logic [3:0]  bank_open_o;
	wire logic        data_oe_o, strobe_oe_o, power_down_o, self_refresh_o;
	logic [15:0]      mem [int];
	int               n_mismatch = 0;
	int               cmp_count  = 0;
	int               e;

	ddr2_ctl_model u_ctl (.sys_clk_i(sys_clk_i), .clk_en_o(clk_en_i),
		.cs_n_o(chip_select_n_i),
		.code_o({row_strobe_n_i, col_strobe_n_i, write_enable_n_i}),
		.bank_o(bank_select_i), .addr_o(multiplexed_address_i),
		.d_rise_o(wd_r), .d_fall_o(wd_f), .m_rise_o(msk_r),
		.m_fall_o(msk_f), .wstb_o(wr_strobe_i));
	ddr2_sdram_command_interface uut (.sys_clk_i(sys_clk_i),
		.reset_i(reset_i), .clk_en_i(clk_en_i),
		.chip_select_n_i(chip_select_n_i), .row_strobe_n_i(row_strobe_n_i),
		.col_strobe_n_i(col_strobe_n_i), .write_enable_n_i(write_enable_n_i),
		.bank_select_i(bank_select_i),
		.multiplexed_address_i(multiplexed_address_i),
		.wr_data_rise_i(wd_r), .wr_data_fall_i(wd_f),
		.byte_write_mask_rise_i(msk_r), .byte_write_mask_fall_i(msk_f),
		.wr_strobe_i(wr_strobe_i), .speed_grade_i(grade),
		.posted_column_delay_i(pdly), .burst_len8_i(bl8),
		.burst_interleave_i(il), .rd_data_rise_o(rd_data_rise_o),
		.rd_data_fall_o(rd_data_fall_o), .data_oe_o(data_oe_o),
		.strobe_oe_o(strobe_oe_o), .bank_open_o(bank_open_o),
		.power_down_o(power_down_o), .self_refresh_o(self_refresh_o),
		.cmd_error_o(cmd_error_o));

	always #12.5 sys_clk_i = ~sys_clk_i;

	// ------
	// helpers
	// ------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic close_out;
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// upper column bits stay put, only the burst-sized field wraps
	function automatic int col_of(input int s, input int n, input logic b8,
		input logic ilv);
		int m;
		m = b8 ? 8 : 4;
		if (ilv)
			return s ^ n;
		return (s & ~(m - 1)) | ((s + n) & (m - 1));
	endfunction

	function automatic int key_of(input int b, input logic [12:0] r,
		input int c);
		return (b << 12) | (int'(r[1:0]) << 10) | c;
	endfunction

	// ------
	// tests
	// ------
	task automatic corners;
		u_ctl.issue(1'b0, 1'b1, 3'h5, 2'h2, 13'h0000, e);
		@(negedge sys_clk_i);
		check(16'(cmd_error_o), 16'h1);
		@(negedge sys_clk_i);
		check(16'(cmd_error_o), 16'h0);
		u_ctl.issue(1'b1, 1'b1, 3'h3, 2'h1, 13'h1FFF, e);
		u_ctl.issue(1'b0, 1'b1, 3'h0, 2'h0, 13'h0000, e);
		@(negedge sys_clk_i);
		check({11'h0, bank_open_o, cmd_error_o}, 16'h0);
		u_ctl.issue(1'b0, 1'b1, 3'h3, 2'h3, 13'h1FFF, e);
		u_ctl.issue(1'b0, 1'b0, 3'h2, 2'h3, 13'h0000, e);
		repeat (3) @(negedge sys_clk_i);
		check({11'h0, bank_open_o, power_down_o}, 16'h10);
		u_ctl.issue(1'b0, 1'b1, 3'h2, 2'h3, 13'h0000, e);
		u_ctl.issue(1'b0, 1'b0, 3'h7, 2'h0, 13'h0000, e);
		repeat (2) @(negedge sys_clk_i);
		check({10'h0, bank_open_o, power_down_o, self_refresh_o},
			16'h2);
		u_ctl.issue(1'b0, 1'b1, 3'h7, 2'h0, 13'h0000, e);
		u_ctl.issue(1'b0, 1'b0, 3'h1, 2'h0, 13'h0000, e);
		repeat (2) @(negedge sys_clk_i);
		check({14'h0, power_down_o, self_refresh_o}, 16'h1);
		u_ctl.issue(1'b0, 1'b1, 3'h7, 2'h0, 13'h0000, e);
		@(negedge sys_clk_i);
		check({14'h0, power_down_o, self_refresh_o}, 16'h0);
		// refresh with a row open is refused, then one precharge shuts all
		u_ctl.issue(1'b0, 1'b1, 3'h3, 2'h0, 13'h0000, e);
		u_ctl.issue(1'b0, 1'b1, 3'h1, 2'h0, 13'h0000, e);
		@(negedge sys_clk_i);
		check({11'h0, bank_open_o, cmd_error_o}, 16'h3);
		u_ctl.issue(1'b0, 1'b1, 3'h2, 2'h2, 13'h0400, e);
		@(negedge sys_clk_i);
		check({11'h0, bank_open_o, cmd_error_o}, 16'h0);
	endtask

	// two seamless writes (second masked), then an offset read that closes
	task automatic round;
		int          b, rl, m, base, off, c;
		logic [12:0] row;
		logic [35:0] w;
		logic [15:0] old, dat;
		logic [1:0]  g, mk;
		logic [2:0]  d;
		logic        l8, iv;
		b = $urandom % 4;
		row = 13'($urandom);
		g = 2'($urandom);
		d = 3'($urandom % 7);
		l8 = 1'($urandom);
		iv = 1'($urandom);
		m = l8 ? 8 : 4;
		rl = d + (g == 2'h0 ? 7 : 5);
		base = ($urandom % 128) * 8;
		off = $urandom % m;
		@(posedge sys_clk_i);
		grade <= g;
		pdly <= d;
		bl8 <= l8;
		il <= iv;
		u_ctl.issue(1'b0, 1'b1, 3'h3, 2'(b), row, e);
		@(negedge sys_clk_i);
		check({12'h0, bank_open_o}, 16'h1 << b);
		for (int k = 0; k < 2; k++) begin
			u_ctl.issue(1'b0, 1'b1, 3'h4, 2'(b), 13'(base), e);
			for (int s = 0; s < m; s++) begin
				if (s % 2 == 0)
					w = {16'($urandom), 16'($urandom), k ? 4'($urandom) : 4'h0};
				u_ctl.plan[e + rl - 1 + s / 2] = w;
				c = key_of(b, row, col_of(base, s, l8, iv));
				old = mem.exists(c) ? mem[c] : 16'h0;
				{dat, mk} = s % 2 ? {w[19:4], w[1:0]} : {w[35:20], w[3:2]};
				mem[c] = {mk[1] ? old[15:8] : dat[15:8],
					mk[0] ? old[7:0] : dat[7:0]};
			end
			repeat (m / 2 - 2) @(posedge sys_clk_i);
		end
		repeat (rl) @(posedge sys_clk_i);
		u_ctl.issue(1'b0, 1'b1, 3'h5, 2'(b), 13'(base + off) | 13'h0400, e);
		for (int j = 0; j <= rl + m / 2; j++) begin
			@(negedge sys_clk_i);
			check(16'(strobe_oe_o), 16'(j >= rl - 1 && j < rl + m / 2));
			check(16'(data_oe_o), 16'(j >= rl && j < rl + m / 2));
			if (j >= rl && j < rl + m / 2) begin
				c = col_of(base + off, 2 * (j - rl), l8, iv);
				check(rd_data_rise_o, mem[key_of(b, row, c)]);
				c = col_of(base + off, 2 * (j - rl) + 1, l8, iv);
				check(rd_data_fall_o, mem[key_of(b, row, c)]);
			end
			if (j >= rl + m / 2 - 2)
				check(16'(bank_open_o[b]), 16'(j < rl + m / 2 - 1));
			@(posedge sys_clk_i);
		end
	endtask

	initial begin
		void'($urandom(55));
		repeat (3) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		corners();
		$display("corner test done");
		for (int i = 0; i < 30; i++) begin
			round();
			$display("round %0d done", i);
		end
		close_out();
	end

	// a round needs under 60 clocks; this allows well over ten times that
	initial begin
		#500000;
		n_mismatch++;
		close_out();
	end
endmodule
